/* File: rtl/soalu_core.sv */
// Single-operand execution datapath with an AXI4-Lite register slave
//
// How it works
// - Zero fill writes zero, sets Z only
// - Invert complements; N,Z from result, V=0, C=1
// - Plus one; V when operand was max positive
// - Minus one; V when operand was min negative
// - Sign flip; V when result min negative, C=nonzero
// - Probe keeps operand, sets N Z, clears V C
// - Signed halve shifts right, keeps sign, C=bit0
// - Signed double shifts left, zero fill, C=old top
// - Shifts and rotates: N,Z from result, V=N^C
// - Rotate right through carry, seventeen-bit ring, nine-bit in byte form
// - Rotate left through carry, C from top bit
// - Byte exchange swaps bytes; flags from low byte
// - Carry add adds carry for multiword arithmetic
// - Instruction bit 15 selects byte operation
// - Byte op in register mode touches low byte
// - Carry add: with carry in set, V at max positive, C at all ones
// - Carry sub: V at min negative, C cleared at 0 when carry in set
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module soalu_core
   import soalu_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address channel
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // Write data channel
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // Write response channel
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // Read address channel
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // Read data channel
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Datapath results
   output logic [15:0]      alu_result,
   output logic [3:0]       alu_flags,
   output logic             exec_done
);

   // Top bit of the operand for the selected width
   function automatic logic top_bit(input logic [15:0] x, input logic is_byte);
      top_bit = is_byte ? x[7] : x[15];
   endfunction

   // All-zero test over the selected width
   function automatic logic is_zero(input logic [15:0] x, input logic is_byte);
      is_zero = is_byte ? (x[7:0] == 8'h00) : (x == 16'h0000);
   endfunction

   // Byte-lane merge for register writes
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // Register state
   logic [15:0] operand;
   logic [15:0] instr;
   logic [3:0]  flags;
   logic [15:0] result;
   logic        go;
   logic        illegal;
   logic        done;

   // Write channel holding registers
   logic        aw_held;
   logic [4:0]  aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_fire;

   // Decoded instruction fields
   logic        is_byte;
   logic [8:0]  opc;
   logic        reg_mode;

   // Next values from the datapath
   logic [15:0] next_result;
   logic [3:0]  next_flags;
   logic        next_illegal;

   assign is_byte  = instr[INSTR_BYTE];
   assign opc      = instr[14:6];
   assign reg_mode = (instr[DST_MODE_HI:DST_MODE_LO] == 3'b000);

   // Datapath: one operation per issued instruction
   always_comb begin
      logic [15:0] mask;
      logic [15:0] maxp;
      logic [15:0] minn;
      logic [15:0] x;
      logic [15:0] r;
      logic        cin;
      logic        n;
      logic        z;
      logic        v;
      logic        c;
      logic        shift_grp;
      mask = is_byte ? B_ONES : W_ONES;
      maxp = is_byte ? B_MAX_POS : W_MAX_POS;
      minn = is_byte ? B_MIN_NEG : W_MIN_NEG;
      x    = operand & mask;
      cin  = flags[FLAG_C];
      r    = x;
      v    = flags[FLAG_V];
      c    = cin;
      n    = 1'b0;
      z    = 1'b0;
      shift_grp    = 1'b0;
      next_illegal = 1'b0;
      if ({instr[15], opc} == OPC_BYTE_EXCH) begin
         // Word only: a set bit 15 would be a different instruction
         r = {x[7:0], x[15:8]};
         v = 1'b0;
         c = 1'b0;
      end else begin
         case (opc)
            OPC_ZERO_FILL: begin
               r = 16'h0000;
               v = 1'b0;
               c = 1'b0;
            end
            OPC_INVERT: begin
               r = ~x & mask;
               v = 1'b0;
               c = 1'b1;
            end
            OPC_PLUS_ONE: begin
               r = (x + 16'h0001) & mask;
               v = (x == maxp);
            end
            OPC_MINUS_ONE: begin
               r = (x - 16'h0001) & mask;
               v = (x == minn);
            end
            OPC_SIGN_FLIP: begin
               r = (16'h0000 - x) & mask;
               v = (r == minn);
               c = (r != 16'h0000);
            end
            OPC_CARRY_ADD: begin
               r = (x + {15'h0000, cin}) & mask;
               v = (x == maxp) && cin;
               c = (x == mask) && cin;
            end
            OPC_CARRY_SUB: begin
               r = (x - {15'h0000, cin}) & mask;
               v = (x == minn);
               c = !((x == 16'h0000) && cin);
            end
            OPC_PROBE: begin
               v = 1'b0;
               c = 1'b0;
            end
            OPC_ROT_RIGHT: begin
               r = is_byte ? {8'h00, cin, x[7:1]} : {cin, x[15:1]};
               c = x[0];
               shift_grp = 1'b1;
            end
            OPC_ROT_LEFT: begin
               r = ({x[14:0], cin}) & mask;
               c = top_bit(x, is_byte);
               shift_grp = 1'b1;
            end
            OPC_HALVE: begin
               r = is_byte ? {8'h00, x[7], x[7:1]} : {x[15], x[15:1]};
               c = x[0];
               shift_grp = 1'b1;
            end
            OPC_DOUBLE: begin
               r = ({x[14:0], 1'b0}) & mask;
               c = top_bit(x, is_byte);
               shift_grp = 1'b1;
            end
            default: begin
               // Not a single-operand code: mark illegal, pass the operand through, keep the flags
               next_illegal = 1'b1;
            end
         endcase
      end
      // Byte exchange takes its flags from the low byte of the word
      n = top_bit(r, is_byte);
      z = is_zero(r, is_byte);
      if ({instr[15], opc} == OPC_BYTE_EXCH) begin
         n = r[7];
         z = (r[7:0] == 8'h00);
      end
      if (shift_grp) begin
         v = n ^ c;
      end
      if (next_illegal) begin
         next_result = operand;
         next_flags  = flags;
      end else begin
         // Register-mode byte ops keep the upper byte of the register
         if (is_byte) begin
            next_result = {reg_mode ? operand[15:8] : 8'h00, r[7:0]};
         end else begin
            next_result = r;
         end
         next_flags = {n, z, v, c};
      end
   end

   // Write channel: address and data may arrive in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 5'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // Write response; unmapped or read-only targets answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr == ADDR_OPERAND || aw_addr == ADDR_INSTR || aw_addr == ADDR_FLAGS) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Operand register, written by software only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         operand <= OPERAND_RST;
      end else if (wr_fire && aw_addr == ADDR_OPERAND) begin
         operand <= merge16(operand, w_data, w_strb);
      end
   end

   // Instruction register; a write issues the instruction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr <= INSTR_RST;
         go    <= 1'b0;
      end else begin
         go <= wr_fire && (aw_addr == ADDR_INSTR);
         if (wr_fire && aw_addr == ADDR_INSTR) begin
            instr <= merge16(instr, w_data, w_strb);
         end
      end
   end

   // Condition flags; execution wins over a software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= FLAGS_RST;
      end else if (go) begin
         flags <= next_flags;
      end else if (wr_fire && aw_addr == ADDR_FLAGS && w_strb[0]) begin
         flags <= w_data[3:0];
      end
   end

   // Result and status, updated one cycle after the issue
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result  <= 16'h0000;
         illegal <= 1'b0;
         done    <= 1'b0;
      end else if (go) begin
         result  <= next_result;
         illegal <= next_illegal;
         done    <= 1'b1;
      end else if (wr_fire && aw_addr == ADDR_INSTR) begin
         // A fresh issue clears the sticky completion bit
         done <= 1'b0;
      end
   end

   // Completion pulse for the surrounding pipeline
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exec_done <= 1'b0;
      end else begin
         exec_done <= go;
      end
   end

   assign alu_result = result;
   assign alu_flags  = flags;

   // Read channel: one read outstanding, data registered
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         case (s_axi_araddr)
            ADDR_OPERAND: s_axi_rdata <= {16'h0000, operand};
            ADDR_INSTR:   s_axi_rdata <= {16'h0000, instr};
            ADDR_FLAGS:   s_axi_rdata <= {28'h0000000, flags};
            ADDR_RESULT:  s_axi_rdata <= {16'h0000, result};
            ADDR_STATUS: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rdata[STAT_BUSY]    <= go;
               s_axi_rdata[STAT_ILLEGAL] <= illegal;
               s_axi_rdata[STAT_DONE]    <= done;
               s_axi_rdata[STAT_DST_LO +: 6] <= instr[5:0];
            end
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // soalu_core

/* File: rtl/soalu_pkg.sv */
// Constants for the single-operand execution datapath and its register map
package soalu_pkg;

   // Register byte addresses on the AXI4-Lite slave
   localparam logic [4:0] ADDR_OPERAND = 5'h00;
   localparam logic [4:0] ADDR_INSTR   = 5'h04;
   localparam logic [4:0] ADDR_FLAGS   = 5'h08;
   localparam logic [4:0] ADDR_RESULT  = 5'h0c;
   localparam logic [4:0] ADDR_STATUS  = 5'h10;

   // Flag register layout
   localparam int FLAG_C = 0;
   localparam int FLAG_V = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;

   // Status register layout
   localparam int STAT_BUSY    = 0;
   localparam int STAT_ILLEGAL = 1;
   localparam int STAT_DONE    = 2;
   localparam int STAT_DST_LO  = 8;

   // Instruction fields
   localparam int INSTR_BYTE   = 15;
   localparam int DST_MODE_HI  = 5;
   localparam int DST_MODE_LO  = 3;

   // Reset values
   localparam logic [15:0] OPERAND_RST = 16'h0000;
   localparam logic [15:0] INSTR_RST   = 16'h0000;
   localparam logic [3:0]  FLAGS_RST   = 4'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Operation codes, bits 14..6 of the instruction
   localparam logic [8:0] OPC_ZERO_FILL  = 9'h028;
   localparam logic [8:0] OPC_INVERT     = 9'h029;
   localparam logic [8:0] OPC_PLUS_ONE   = 9'h02a;
   localparam logic [8:0] OPC_MINUS_ONE  = 9'h02b;
   localparam logic [8:0] OPC_SIGN_FLIP  = 9'h02c;
   localparam logic [8:0] OPC_CARRY_ADD  = 9'h02d;
   localparam logic [8:0] OPC_CARRY_SUB  = 9'h02e;
   localparam logic [8:0] OPC_PROBE      = 9'h02f;
   localparam logic [8:0] OPC_ROT_RIGHT  = 9'h030;
   localparam logic [8:0] OPC_ROT_LEFT   = 9'h031;
   localparam logic [8:0] OPC_HALVE      = 9'h032;
   localparam logic [8:0] OPC_DOUBLE     = 9'h033;
   // Full ten-bit code, word form only
   localparam logic [9:0] OPC_BYTE_EXCH  = 10'h003;

   // Operand limits, word and byte
   localparam logic [15:0] W_MAX_POS = 16'h7fff;
   localparam logic [15:0] W_MIN_NEG = 16'h8000;
   localparam logic [15:0] W_ONES    = 16'hffff;
   localparam logic [15:0] B_MAX_POS = 16'h007f;
   localparam logic [15:0] B_MIN_NEG = 16'h0080;
   localparam logic [15:0] B_ONES    = 16'h00ff;

endpackage

/* File: test/soalu_core_sva.sv */
// Port-level checker for the single-operand datapath register slave
`timescale 1ns/10ps
module soalu_core_chk
   import soalu_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Register bus
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Datapath outputs
   input  wire logic [15:0] alu_result,
   input  wire logic [3:0]  alu_flags,
   input  wire logic        exec_done
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Both write halves taken at one edge
   logic wr_go;
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_r_next;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_next: assert property (p_r_next) else $error("read answer late");
   property p_busy_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy_block: assert property (p_busy_block) else $error("write taken while answer open");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr > ADDR_STATUS)
         |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_ro_write;
      wr_go && (s_axi_awaddr == ADDR_RESULT) |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("result write not refused");
   property p_exec;
      wr_go && (s_axi_awaddr == ADDR_INSTR) |-> ##[2:4] exec_done;
   endproperty
   a_exec: assert property (p_exec) else $error("instruction not executed");
   property p_pulse;
      exec_done |=> !exec_done;
   endproperty
   a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
   property p_res_quiet;
      $changed(alu_result) |-> exec_done;
   endproperty
   a_res_quiet: assert property (p_res_quiet) else $error("result moved without execution");
   property p_flag_quiet;
      $changed(alu_flags) |-> exec_done || $rose(s_axi_bvalid);
   endproperty
   a_flag_quiet: assert property (p_flag_quiet) else $error("flags moved without cause");
endmodule // soalu_core_chk

bind soalu_core soalu_core_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .alu_result, .alu_flags, .exec_done);

/* File: test/tb_single_operand_alu.sv */
// Self-checking bench for the single-operand datapath slave
`timescale 1ns/10ps
module tb_single_operand_alu
   import soalu_pkg::*;
;
   typedef struct {
      logic [15:0] instr;
      logic [15:0] op;
      logic [3:0]  fin;
      logic [15:0] res;
      logic [3:0]  fout;
   } soalu_vec_t;
   localparam logic       W = 1'b0;
   localparam logic       B = 1'b1;
   localparam logic [5:0] R = 6'h01;

   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, exec_done;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, alu_flags;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] alu_result;
   int          err_total = 0;
   int          samples_checked = 0;

   // Operand, flags in, expected result and flags {N,Z,V,C}
   soalu_vec_t vecs [0:36] = '{
      '{{W,OPC_ZERO_FILL,R}, 16'hffff, 4'hf, 16'h0000, 4'h4},
      '{{W,OPC_INVERT,R}, 16'h16db, 4'h6, 16'he924, 4'h9},
      '{{W,OPC_PLUS_ONE,R}, 16'h7fff, 4'h1, 16'h8000, 4'hb},
      '{{W,OPC_PLUS_ONE,R}, 16'hffff, 4'h0, 16'h0000, 4'h4},
      '{{W,OPC_MINUS_ONE,R}, 16'h8000, 4'h1, 16'h7fff, 4'h3},
      '{{W,OPC_MINUS_ONE,R}, 16'h0001, 4'h8, 16'h0000, 4'h4},
      '{{W,OPC_SIGN_FLIP,R}, 16'h8000, 4'h0, 16'h8000, 4'hb},
      '{{W,OPC_SIGN_FLIP,R}, 16'h0000, 4'hf, 16'h0000, 4'h4},
      '{{W,OPC_SIGN_FLIP,R}, 16'h0008, 4'h0, 16'hfff8, 4'h9},
      '{{W,OPC_PROBE,R}, 16'h8001, 4'h3, 16'h8001, 4'h8},
      '{{W,OPC_HALVE,R}, 16'h8001, 4'h0, 16'hc000, 4'h9},
      '{{W,OPC_HALVE,R}, 16'h0001, 4'h8, 16'h0000, 4'h7},
      '{{W,OPC_DOUBLE,R}, 16'h4000, 4'h0, 16'h8000, 4'ha},
      '{{W,OPC_DOUBLE,R}, 16'h8000, 4'h0, 16'h0000, 4'h7},
      '{{W,OPC_ROT_RIGHT,R}, 16'h0001, 4'h1, 16'h8000, 4'h9},
      '{{W,OPC_ROT_LEFT,R}, 16'h8000, 4'h0, 16'h0000, 4'h7},
      '{{W,OPC_ROT_LEFT,R}, 16'h0001, 4'h1, 16'h0003, 4'h0},
      '{{OPC_BYTE_EXCH,R}, 16'h7fff, 4'hf, 16'hff7f, 4'h0},
      '{{OPC_BYTE_EXCH,R}, 16'h00ff, 4'h0, 16'hff00, 4'h4},
      '{{W,OPC_CARRY_ADD,R}, 16'h7fff, 4'h1, 16'h8000, 4'ha},
      '{{W,OPC_CARRY_ADD,R}, 16'hffff, 4'h1, 16'h0000, 4'h5},
      '{{W,OPC_CARRY_SUB,R}, 16'h0000, 4'h1, 16'hffff, 4'h8},
      '{{W,OPC_CARRY_SUB,R}, 16'h8000, 4'h0, 16'h8000, 4'hb},
      '{{B,OPC_PLUS_ONE,R}, 16'h127f, 4'h0, 16'h1280, 4'ha},
      '{{B,OPC_ZERO_FILL,R}, 16'habcd, 4'hf, 16'hab00, 4'h4},
      '{{B,OPC_ZERO_FILL,6'h08}, 16'habcd, 4'hf, 16'h0000, 4'h4},
      '{{B,OPC_HALVE,R}, 16'h0081, 4'h0, 16'h00c0, 4'h9},
      '{{B,OPC_ROT_LEFT,R}, 16'h0080, 4'h0, 16'h0000, 4'h7},
      '{{B,OPC_CARRY_SUB,R}, 16'hff00, 4'h1, 16'hffff, 4'h8},
      '{{B,OPC_INVERT,R}, 16'h5a0f, 4'h0, 16'h5af0, 4'h9},
      '{{B,OPC_SIGN_FLIP,R}, 16'h3380, 4'h0, 16'h3380, 4'hb},
      '{{B,OPC_CARRY_ADD,R}, 16'h00ff, 4'h1, 16'h0000, 4'h5},
      '{{B,OPC_ROT_RIGHT,R}, 16'h0001, 4'h1, 16'h0080, 4'h9},
      '{{B,OPC_MINUS_ONE,R}, 16'h4480, 4'h0, 16'h447f, 4'h2},
      '{{B,OPC_PROBE,R}, 16'h0080, 4'h3, 16'h0080, 4'h8},
      '{{B,OPC_DOUBLE,R}, 16'h0040, 4'h0, 16'h0080, 4'ha},
      '{{B,9'h003,R}, 16'h1234, 4'h5, 16'h1234, 4'h5}};

   soalu_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alu_result,
      .alu_flags, .exec_done);

   // Free-running 200 MHz clock
   always #2.5 aclk = ~aclk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test;
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Both halves offered together; answer accepted one cycle late to stall it
   task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rsp);
      bit aw_ok = 0;
      bit w_ok = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!(aw_ok && w_ok && s_axi_bvalid));
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rsp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   // Reset values, read-only and unmapped places refused
   task automatic t_map;
      logic [31:0] d;
      logic [1:0]  rsp;
      for (int a = 0; a <= 20; a += 4) begin
         rd(a[4:0], d, rsp);
         chk("reset_value", d, 32'h0);
         chk("rresp", {30'h0, rsp}, {30'h0, (a == 20) ? RESP_SLVERR : RESP_OKAY});
      end
      wr(ADDR_RESULT, 32'h0000_5555, rsp);
      chk("bresp_ro", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(5'h1c, 32'h0000_5555, rsp);
      chk("bresp_unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(ADDR_FLAGS, 32'hffff_fffa, rsp);
      rd(ADDR_FLAGS, d, rsp);
      chk("flags_rw", d, 32'h0000_000a);
      rd(ADDR_RESULT, d, rsp);
      chk("result_kept", d, 32'h0);
   endtask

   // Every operation, word and byte, with flags, result and status
   task automatic t_ops;
      logic [31:0] d;
      logic [1:0]  rsp;
      logic        ill;
      int          n;
      foreach (vecs[i]) begin
         wr(ADDR_OPERAND, {16'h0, vecs[i].op}, rsp);
         wr(ADDR_FLAGS, {28'h0, vecs[i].fin}, rsp);
         wr(ADDR_INSTR, {16'h0, vecs[i].instr}, rsp);
         n = 0;
         while (exec_done !== 1'b1 && n < 10) begin
            @(posedge aclk);
            n++;
         end
         chk("exec_done", {31'h0, exec_done}, 32'h1);
         chk("alu_result", {16'h0, alu_result}, {16'h0, vecs[i].res});
         chk("alu_flags", {28'h0, alu_flags}, {28'h0, vecs[i].fout});
         rd(ADDR_RESULT, d, rsp);
         chk("result_reg", d, {16'h0, vecs[i].res});
         ill = (vecs[i].instr[15:6] == 10'h203);
         rd(ADDR_STATUS, d, rsp);
         chk("status", d, {18'h0, vecs[i].instr[5:0], 5'h0, 1'b1, ill, 1'b0});
      end
   endtask

   // Reset in mid-run clears the datapath outputs
   task automatic t_mid_reset;
      logic [31:0] d;
      logic [1:0]  rsp;
      do_reset();
      @(posedge aclk);
      chk("result_after_reset", {16'h0, alu_result}, 32'h0);
      chk("flags_after_reset", {28'h0, alu_flags}, 32'h0);
      rd(ADDR_OPERAND, d, rsp);
      chk("operand_after_reset", d, 32'h0);
   endtask

   // Hang guard, far beyond the roughly one thousand cycles needed
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      end_of_test();
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      s_axi_awaddr = 5'h0;
      s_axi_araddr = 5'h0;
      s_axi_awprot = 3'h0;
      s_axi_arprot = 3'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      do_reset();
      t_map();
      t_ops();
      t_mid_reset();
      end_of_test();
   end
endmodule // tb_single_operand_alu
